/* core/acr_amp_control_regs.sv */
// Control registers, comparator readout and interrupt requests of the amplifier module.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module acr_amp_control_regs
   import acr_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Register port.
   input wire logic [ACR_ADDR_W-1:0] reg_addr_in,
   input wire logic [ACR_DATA_W-1:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [ACR_DATA_W-1:0] reg_rdata_out,
   // Schmitt-filtered comparator outputs from the analog side.
   input wire logic amp1_cmp_in,
   input wire logic amp2_cmp_in,
   // Global interrupt mask from the condition code register.
   input wire logic irq_mask_in,
   // Interrupt requests and wake-up.
   output logic amp1_irq_req_out,
   output logic amp2_irq_req_out,
   output logic amp1_cpu_irq_out,
   output logic amp2_cpu_irq_out,
   output logic wake_out,
   // Amplifier 1 analog controls.
   output logic amp1_autozero_out,
   output logic [2:0] amp1_gain_sel_out,
   output logic [1:0] amp1_plus_src_out,
   output logic [1:0] amp1_minus_src_out,
   output logic amp1_noninv_out,
   output logic amp1_comparator_out,
   output logic amp1_minus_ground_out,
   output logic amp1_minus_float_out,
   output logic amp1_minus_pin_out,
   output logic amp1_power_on_out,
   // Amplifier 2 analog controls.
   output logic amp2_autozero_out,
   output logic [2:0] amp2_gain_sel_out,
   output logic [1:0] amp2_plus_src_out,
   output logic [1:0] amp2_minus_src_out,
   output logic amp2_noninv_out,
   output logic amp2_comparator_out,
   output logic amp2_minus_ground_out,
   output logic amp2_minus_float_out,
   output logic amp2_minus_pin_out,
   output logic amp2_power_on_out,
   // Amplifier 3 and module power.
   output logic amp3_power_on_out,
   output logic module_enable_out,
   // Reference voltages.
   output logic ref1_enable_out,
   output logic [2:0] ref1_level_out,
   output logic ref1_to_plus_out,
   output logic ref2_enable_out,
   output logic [2:0] ref2_level_out,
   output logic ref2_to_plus_out,
   output logic ref_cell_enable_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions shared by both programmable amplifiers.

   // Inverting for the reference and bandgap sources, non-inverting for the pin and floating input.
   function automatic logic plus_is_noninv(input logic [1:0] plus_src);
      plus_is_noninv = (plus_src == ACR_PLUS_PIN) || (plus_src == ACR_PLUS_FLOAT);
   endfunction

   // One-hot decode of the negative input selection.
   function automatic logic [2:0] minus_decode(input logic [1:0] minus_src);
      logic [2:0] sel;
      sel = 3'h0;
      if (minus_src[1]) begin
         sel[2] = 1'b1;
      end else if (minus_src == ACR_MINUS_FLOAT) begin
         sel[1] = 1'b1;
      end else begin
         sel[0] = 1'b1;
      end
      minus_decode = sel;
   endfunction

   // Read view of the interrupt register: value bits come from the synchronised comparators.
   function automatic logic [7:0] irq_view(input logic [7:0] ctrl, input logic [1:0] cmp);
      logic [7:0] view;
      view = ctrl & ACR_IRQ_WRITE_MASK;
      view[ACR_AMP1_OUT_VALUE_BIT] = cmp[0];
      view[ACR_AMP2_OUT_VALUE_BIT] = cmp[1];
      irq_view = view;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State register and next-state logic.

   acr_state_s st;
   acr_state_s next_st;
   logic [2:0] amp1_minus_dec;
   logic [2:0] amp2_minus_dec;

   always_comb begin
      next_st = st;
      // Comparator outputs are asynchronous to the system clock.
      next_st.cmp_meta = {amp2_cmp_in, amp1_cmp_in};
      next_st.cmp_sync = st.cmp_meta;
      if (reg_write_in) begin
         case (reg_addr_in)
            ACR_AMP1_CONTROL_OFS: begin
               next_st.amp1_control = reg_wdata_in;
            end
            ACR_AMP2_CONTROL_OFS: begin
               next_st.amp2_control = reg_wdata_in;
            end
            ACR_AMP3_CONTROL_OFS: begin
               next_st.amp3_power_on = reg_wdata_in[ACR_AMP3_POWER_BIT];
            end
            ACR_AMP_IRQ_READOUT_OFS: begin
               next_st.irq_control = reg_wdata_in & ACR_IRQ_WRITE_MASK;
            end
            ACR_VREF_SELECT_CONTROL_OFS: begin
               next_st.vref_control = reg_wdata_in;
            end
            default: begin
               next_st.irq_control = st.irq_control;
            end
         endcase
      end
      // Read data stands only in the cycle after the read strobe.
      next_st.rd_data = 8'h00;
      if (reg_read_in) begin
         case (reg_addr_in)
            ACR_AMP1_CONTROL_OFS: begin
               next_st.rd_data = st.amp1_control;
            end
            ACR_AMP2_CONTROL_OFS: begin
               next_st.rd_data = st.amp2_control;
            end
            ACR_AMP3_CONTROL_OFS: begin
               next_st.rd_data = {st.amp3_power_on, 7'h00};
            end
            ACR_AMP_IRQ_READOUT_OFS: begin
               next_st.rd_data = irq_view(st.irq_control, st.cmp_sync);
            end
            ACR_VREF_SELECT_CONTROL_OFS: begin
               next_st.rd_data = st.vref_control;
            end
            default: begin
               next_st.rd_data = ACR_UNMAPPED_READ;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= ACR_STATE_RST;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt requests.

   // Level requests with no latched flag: they drop as soon as the match or the enable goes away.
   assign amp1_irq_req_out = st.irq_control[ACR_AMP1_IRQ_ENABLE_BIT]
      && (st.cmp_sync[0] == st.irq_control[ACR_AMP1_IRQ_POLARITY_BIT]);
   assign amp2_irq_req_out = st.irq_control[ACR_AMP2_IRQ_ENABLE_BIT]
      && (st.cmp_sync[1] == st.irq_control[ACR_AMP2_IRQ_POLARITY_BIT]);
   assign amp1_cpu_irq_out = amp1_irq_req_out && !irq_mask_in;
   assign amp2_cpu_irq_out = amp2_irq_req_out && !irq_mask_in;
   // Wake-up does not look at the mask, since halt entry clears it anyway.
   assign wake_out = amp1_irq_req_out || amp2_irq_req_out;

   ////////////////////////////////////////////////////////////////////////////
   // Analog controls.

   assign reg_rdata_out = st.rd_data;

   assign amp1_minus_dec = minus_decode(st.amp1_control[ACR_MINUS_MSB:ACR_MINUS_LSB]);
   assign amp2_minus_dec = minus_decode(st.amp2_control[ACR_MINUS_MSB:ACR_MINUS_LSB]);

   assign amp1_autozero_out = st.amp1_control[ACR_AUTOZERO_BIT];
   assign amp1_gain_sel_out = st.amp1_control[ACR_GAIN_MSB:ACR_GAIN_LSB];
   assign amp1_plus_src_out = st.amp1_control[ACR_PLUS_MSB:ACR_PLUS_LSB];
   assign amp1_minus_src_out = st.amp1_control[ACR_MINUS_MSB:ACR_MINUS_LSB];
   assign amp1_noninv_out = plus_is_noninv(amp1_plus_src_out);
   assign amp1_comparator_out = amp1_gain_sel_out == ACR_GAIN_COMPARATOR;
   assign amp1_minus_ground_out = amp1_minus_dec[0];
   assign amp1_minus_float_out = amp1_minus_dec[1];
   assign amp1_minus_pin_out = amp1_minus_dec[2];
   assign amp1_power_on_out = st.irq_control[ACR_AMP1_POWER_BIT];

   assign amp2_autozero_out = st.amp2_control[ACR_AUTOZERO_BIT];
   assign amp2_gain_sel_out = st.amp2_control[ACR_GAIN_MSB:ACR_GAIN_LSB];
   assign amp2_plus_src_out = st.amp2_control[ACR_PLUS_MSB:ACR_PLUS_LSB];
   assign amp2_minus_src_out = st.amp2_control[ACR_MINUS_MSB:ACR_MINUS_LSB];
   assign amp2_noninv_out = plus_is_noninv(amp2_plus_src_out);
   assign amp2_comparator_out = amp2_gain_sel_out == ACR_GAIN_COMPARATOR;
   assign amp2_minus_ground_out = amp2_minus_dec[0];
   assign amp2_minus_float_out = amp2_minus_dec[1];
   assign amp2_minus_pin_out = amp2_minus_dec[2];
   assign amp2_power_on_out = st.irq_control[ACR_AMP2_POWER_BIT];

   // On parts without the third amplifier, software must leave this bit clear.
   assign amp3_power_on_out = st.amp3_power_on;
   assign module_enable_out = amp1_power_on_out || amp2_power_on_out || amp3_power_on_out;

   assign ref1_enable_out = st.vref_control[ACR_REF1_ENABLE_BIT];
   assign ref1_level_out = st.vref_control[ACR_REF1_LEVEL_MSB:ACR_REF1_LEVEL_LSB];
   assign ref1_to_plus_out = (amp1_plus_src_out == ACR_PLUS_REF) && ref1_enable_out;
   assign ref2_enable_out = st.vref_control[ACR_REF2_ENABLE_BIT];
   assign ref2_level_out = st.vref_control[ACR_REF2_LEVEL_MSB:ACR_REF2_LEVEL_LSB];
   assign ref2_to_plus_out = (amp2_plus_src_out == ACR_PLUS_REF) && ref2_enable_out;
   // The resistive ladder idles when neither reference is enabled.
   assign ref_cell_enable_out = ref1_enable_out || ref2_enable_out;

endmodule

`default_nettype wire

/* core/acr_pkg.sv */
// Package for the amplifier control register bank: offsets, field positions, reset values.
package acr_pkg;

   localparam int ACR_ADDR_W = 8;
   localparam int ACR_DATA_W = 8;

   // Register offsets.
   localparam logic [7:0] ACR_AMP1_CONTROL_OFS = 8'h1b;
   localparam logic [7:0] ACR_AMP2_CONTROL_OFS = 8'h1c;
   localparam logic [7:0] ACR_AMP3_CONTROL_OFS = 8'h1d;
   localparam logic [7:0] ACR_AMP_IRQ_READOUT_OFS = 8'h1e;
   localparam logic [7:0] ACR_VREF_SELECT_CONTROL_OFS = 8'h1f;

   // Reset values.
   localparam logic [7:0] ACR_AMP_CONTROL_RST = 8'h00;
   localparam logic [7:0] ACR_IRQ_READOUT_RST = 8'h00;
   localparam logic [7:0] ACR_VREF_CONTROL_RST = 8'h00;
   localparam logic ACR_AMP3_POWER_RST = 1'b0;
   localparam logic [7:0] ACR_UNMAPPED_READ = 8'h00;

   // Programmable amplifier control register fields.
   localparam int ACR_AUTOZERO_BIT = 7;
   localparam int ACR_GAIN_MSB = 6;
   localparam int ACR_GAIN_LSB = 4;
   localparam int ACR_PLUS_MSB = 3;
   localparam int ACR_PLUS_LSB = 2;
   localparam int ACR_MINUS_MSB = 1;
   localparam int ACR_MINUS_LSB = 0;

   // Third amplifier control register field.
   localparam int ACR_AMP3_POWER_BIT = 7;

   // Interrupt and readout register fields.
   localparam int ACR_AMP1_IRQ_ENABLE_BIT = 7;
   localparam int ACR_AMP1_IRQ_POLARITY_BIT = 6;
   localparam int ACR_AMP1_OUT_VALUE_BIT = 5;
   localparam int ACR_AMP1_POWER_BIT = 4;
   localparam int ACR_AMP2_IRQ_ENABLE_BIT = 3;
   localparam int ACR_AMP2_IRQ_POLARITY_BIT = 2;
   localparam int ACR_AMP2_OUT_VALUE_BIT = 1;
   localparam int ACR_AMP2_POWER_BIT = 0;
   localparam logic [7:0] ACR_IRQ_WRITE_MASK = 8'hdd;

   // Reference control register fields.
   localparam int ACR_REF2_ENABLE_BIT = 7;
   localparam int ACR_REF2_LEVEL_MSB = 6;
   localparam int ACR_REF2_LEVEL_LSB = 4;
   localparam int ACR_REF1_ENABLE_BIT = 3;
   localparam int ACR_REF1_LEVEL_MSB = 2;
   localparam int ACR_REF1_LEVEL_LSB = 0;

   // Field encodings.
   localparam logic [2:0] ACR_GAIN_COMPARATOR = 3'h7;
   localparam logic [1:0] ACR_PLUS_REF = 2'h0;
   localparam logic [1:0] ACR_PLUS_PIN = 2'h1;
   localparam logic [1:0] ACR_PLUS_BANDGAP = 2'h2;
   localparam logic [1:0] ACR_PLUS_FLOAT = 2'h3;
   localparam logic [1:0] ACR_MINUS_GROUND = 2'h0;
   localparam logic [1:0] ACR_MINUS_FLOAT = 2'h1;

   // Whole state of the block.
   typedef struct packed {
      logic [7:0] amp1_control;
      logic [7:0] amp2_control;
      logic amp3_power_on;
      logic [7:0] irq_control;
      logic [7:0] vref_control;
      logic [1:0] cmp_meta;
      logic [1:0] cmp_sync;
      logic [7:0] rd_data;
   } acr_state_s;

   localparam acr_state_s ACR_STATE_RST = '{
      amp1_control: ACR_AMP_CONTROL_RST,
      amp2_control: ACR_AMP_CONTROL_RST,
      amp3_power_on: ACR_AMP3_POWER_RST,
      irq_control: ACR_IRQ_READOUT_RST,
      vref_control: ACR_VREF_CONTROL_RST,
      cmp_meta: 2'h0,
      cmp_sync: 2'h0,
      rd_data: 8'h00
   };

endpackage

/* sim/acr_amp_control_props.sv */
// Concurrent checks on the ports of the amplifier control register bank.
`timescale 1ns/10ps
`default_nettype none
module acr_amp_control_props
   import acr_pkg::*;
(
   // Clock, reset and register port.
   input wire logic ref_clk_in, rst_n_in, reg_write_in, reg_read_in, irq_mask_in,
   input wire logic [ACR_ADDR_W-1:0] reg_addr_in,
   input wire logic [ACR_DATA_W-1:0] reg_wdata_in, reg_rdata_out,
   // Watched outputs.
   input wire logic amp1_irq_req_out, amp2_irq_req_out, amp1_cpu_irq_out, amp2_cpu_irq_out, wake_out,
   input wire logic amp1_power_on_out, amp2_power_on_out, amp3_power_on_out, module_enable_out,
   input wire logic amp1_autozero_out, amp2_noninv_out, amp1_minus_pin_out,
   input wire logic ref1_enable_out, ref2_enable_out, ref2_to_plus_out,
   input wire logic [2:0] amp1_gain_sel_out, ref2_level_out,
   input wire logic [1:0] amp2_plus_src_out, amp1_minus_src_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////////////////////////
   AST_CPU_GATE: assert property (
      amp1_cpu_irq_out == (amp1_irq_req_out && !irq_mask_in) && amp2_cpu_irq_out == (amp2_irq_req_out && !irq_mask_in))
      else $error("cpu interrupt not gated by global mask");
   AST_WAKE: assert property (wake_out == (amp1_irq_req_out || amp2_irq_req_out))
      else $error("wake differs from request OR");
   AST_MODULE_OFF: assert property (
      module_enable_out == (amp1_power_on_out || amp2_power_on_out || amp3_power_on_out))
      else $error("module enable differs from power bits");
   AST_AMP1_WRITE: assert property (reg_write_in && reg_addr_in == ACR_AMP1_CONTROL_OFS |=>
      {amp1_autozero_out, amp1_gain_sel_out} == $past(reg_wdata_in[7:4]))
      else $error("amp1 control write not applied");
   AST_POWER_WRITE: assert property (reg_write_in && reg_addr_in == ACR_AMP_IRQ_READOUT_OFS |=>
      amp1_power_on_out == $past(reg_wdata_in[4]) && amp2_power_on_out == $past(reg_wdata_in[0]))
      else $error("power bits not applied");
   AST_AMP3_READ: assert property (reg_read_in && reg_addr_in == ACR_AMP3_CONTROL_OFS |=>
      reg_rdata_out == {amp3_power_on_out, 7'h00})
      else $error("amp3 readback wrong");
   AST_REF_WRITE: assert property (reg_write_in && reg_addr_in == ACR_VREF_SELECT_CONTROL_OFS |=>
      {ref2_enable_out, ref2_level_out, ref1_enable_out} == $past(reg_wdata_in[7:3]))
      else $error("reference write not applied");
   AST_REF2_ROUTE: assert property (ref2_to_plus_out == (amp2_plus_src_out == ACR_PLUS_REF && ref2_enable_out))
      else $error("second reference routing wrong");
   AST_DECODE: assert property (
      amp2_noninv_out == amp2_plus_src_out[0] && amp1_minus_pin_out == amp1_minus_src_out[1])
      else $error("input source decode wrong");
   AST_IDLE_RDATA: assert property (!reg_read_in |=> reg_rdata_out == 8'h00)
      else $error("read data not zero outside read");
   C_CPU1: cover property (amp1_cpu_irq_out);
   C_MASKED2: cover property (amp2_irq_req_out && irq_mask_in);
   C_AMP3_WR: cover property (reg_write_in && reg_addr_in == ACR_AMP3_CONTROL_OFS);
endmodule
`default_nettype wire

/* sim/tb.sv */
// Self-checking testbench for the amplifier control register bank.
`timescale 1ns/10ps
`default_nettype none
module tb;
   import acr_pkg::*;
   logic ref_clk_in = 1'b0, rst_n_in = 1'b0, reg_write_in = 1'b0, reg_read_in = 1'b0;
   logic amp1_cmp_in = 1'b0, amp2_cmp_in = 1'b0, irq_mask_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
   logic amp1_irq_req_out, amp2_irq_req_out, amp1_cpu_irq_out, amp2_cpu_irq_out, wake_out;
   logic amp1_autozero_out, amp1_noninv_out, amp1_comparator_out, amp1_power_on_out;
   logic amp1_minus_ground_out, amp1_minus_float_out, amp1_minus_pin_out;
   logic amp2_autozero_out, amp2_noninv_out, amp2_comparator_out, amp2_power_on_out;
   logic amp2_minus_ground_out, amp2_minus_float_out, amp2_minus_pin_out;
   logic amp3_power_on_out, module_enable_out, ref1_enable_out, ref1_to_plus_out;
   logic ref2_enable_out, ref2_to_plus_out, ref_cell_enable_out;
   logic [2:0] amp1_gain_sel_out, amp2_gain_sel_out, ref1_level_out, ref2_level_out;
   logic [1:0] amp1_plus_src_out, amp1_minus_src_out, amp2_plus_src_out, amp2_minus_src_out;
   int n_errors = 0;
   int check_count = 0;
   logic [31:0] lfsr_state = 32'h0ee9d191;
   logic [7:0] m1 = 8'h00, m2 = 8'h00, m3 = 8'h00, mi = 8'h00, mv = 8'h00, rd_v, a;
   logic e1, e2;

   acr_amp_control_regs uut (.*);

   always #10 ref_clk_in = ~ref_clk_in;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [12:0] exp_amp(input logic [7:0] c);
      return {c, c[2], c[6:4] == 3'h7, c[1:0] == 2'h0, c[1:0] == 2'h1, c[1]};
   endfunction

   // Comparator inputs are held for three edges before any read, so they equal the synchronised value.
   function automatic logic [7:0] exp_rd(input logic [7:0] ad);
      case (ad)
         ACR_AMP1_CONTROL_OFS: return m1;
         ACR_AMP2_CONTROL_OFS: return m2;
         ACR_AMP3_CONTROL_OFS: return m3;
         ACR_AMP_IRQ_READOUT_OFS: return mi | {2'h0, amp1_cmp_in, 3'h0, amp2_cmp_in, 1'b0};
         ACR_VREF_SELECT_CONTROL_OFS: return mv;
         default: return 8'h00;
      endcase
   endfunction

   task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge ref_clk_in);
      reg_addr_in <= ad;
      reg_wdata_in <= d;
      reg_write_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_write_in <= 1'b0;
      case (ad)
         ACR_AMP1_CONTROL_OFS: m1 = d;
         ACR_AMP2_CONTROL_OFS: m2 = d;
         ACR_AMP3_CONTROL_OFS: m3 = d & 8'h80;
         ACR_AMP_IRQ_READOUT_OFS: mi = d & 8'hdd;
         ACR_VREF_SELECT_CONTROL_OFS: mv = d;
         default: ;
      endcase
   endtask

   task rd(input logic [7:0] ad);
      @(posedge ref_clk_in);
      reg_addr_in <= ad;
      reg_read_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_read_in <= 1'b0;
      #1 rd_v = reg_rdata_out;
      chk("rdata", 16'(exp_rd(ad)), 16'(rd_v));
   endtask

   task chk_out;
      e1 = mi[7] && (amp1_cmp_in == mi[6]);
      e2 = mi[3] && (amp2_cmp_in == mi[2]);
      chk("amp1", 16'(exp_amp(m1)), 16'({amp1_autozero_out, amp1_gain_sel_out, amp1_plus_src_out,
         amp1_minus_src_out, amp1_noninv_out, amp1_comparator_out, amp1_minus_ground_out, amp1_minus_float_out,
         amp1_minus_pin_out}));
      chk("amp2", 16'(exp_amp(m2)), 16'({amp2_autozero_out, amp2_gain_sel_out, amp2_plus_src_out,
         amp2_minus_src_out, amp2_noninv_out, amp2_comparator_out, amp2_minus_ground_out, amp2_minus_float_out,
         amp2_minus_pin_out}));
      chk("power", 16'({mi[4], mi[0], m3[7], mi[4] | mi[0] | m3[7]}),
         16'({amp1_power_on_out, amp2_power_on_out, amp3_power_on_out, module_enable_out}));
      chk("vref", 16'({mv, m1[3:2] == 2'h0 && mv[3], m2[3:2] == 2'h0 && mv[7], mv[3] | mv[7]}),
         16'({ref2_enable_out, ref2_level_out, ref1_enable_out, ref1_level_out, ref1_to_plus_out,
         ref2_to_plus_out, ref_cell_enable_out}));
      chk("irq", 16'({e1, e2, e1 && !irq_mask_in, e2 && !irq_mask_in, e1 || e2}),
         16'({amp1_irq_req_out, amp2_irq_req_out, amp1_cpu_irq_out, amp2_cpu_irq_out, wake_out}));
   endtask

   task tally_and_finish;
      if (n_errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      #1 chk_out;
      for (int i = 0; i < 6; i++) rd(8'h1b + 8'(i));
      // Random writes over every register and one unmapped offset, with random comparator and mask levels.
      for (int i = 0; i < 96; i++) begin
         lfsr_state = lfsr(lfsr_state);
         a = 8'h1b + lfsr_state[7:0] % 8'h06;
         wr(a, lfsr_state[15:8]);
         amp1_cmp_in <= lfsr_state[16];
         amp2_cmp_in <= lfsr_state[17];
         irq_mask_in <= lfsr_state[18];
         repeat (3) @(posedge ref_clk_in);
         #1 chk_out;
         rd(a);
      end
      rst_n_in <= 1'b0;
      @(posedge ref_clk_in);
      {m1, m2, m3, mi, mv} = 40'h0;
      #1 chk_out;
      tally_and_finish;
   end

   initial begin
      #100000;
      n_errors++;
      tally_and_finish;
   end
endmodule

bind acr_amp_control_regs acr_amp_control_props u_props (.ref_clk_in, .rst_n_in, .reg_write_in, .reg_read_in,
   .irq_mask_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .amp1_irq_req_out, .amp2_irq_req_out,
   .amp1_cpu_irq_out, .amp2_cpu_irq_out, .wake_out, .amp1_power_on_out, .amp2_power_on_out, .amp3_power_on_out,
   .module_enable_out, .amp1_autozero_out, .amp2_noninv_out, .amp1_minus_pin_out, .ref1_enable_out,
   .ref2_enable_out, .ref2_to_plus_out, .amp1_gain_sel_out, .ref2_level_out, .amp2_plus_src_out,
   .amp1_minus_src_out);
`default_nettype wire
